// ### hdl/plt_link_ctrl.sv
// PHY link-training control registers with an AXI4-Lite slave.
// Summary of operation
// - Compat bit puts PHY into first-generation mode.
// - Compat mode clears training bits beyond 1.1.
// - Crosslink-disable bit stops crosslink training.
// - Speed bit zero: auto Gen2 after first L0 when gen2Permitted and compat bit clear.
// - Speed bit one: no auto change, stay Gen1.
// - Speed bit reset: downstream zero, others one.
// - Retrain write forces LTSSM into Detect.
// - Retrain bit always reads back zero.
// - Write response precedes retrain taking effect.
// - Upstream port retrain waits one millisecond.
// - Sixteen-bit seed, resets to all ones.
// - Seed change reloads and restarts PRBS counter.
//
// Design decision made here: register access over AXI4-Lite.
module plt_link_ctrl #(
    parameter int UP_DELAY = plt_pkg::UP_DELAY_CYCLES
) (
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        downstreamPort,
    input  wire logic        ltssmInL0,
    input  wire logic        gen2Permitted,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output plt_pkg::plt_train_opts_t trainOpts,
    output logic             forceDetect,
    output logic             speedChangeReq,
    output logic [15:0]      prbsValue
);
    typedef enum logic [1:0] {
        RT_IDLE,
        RT_WAIT_RESP,
        RT_DELAY
    } plt_retrain_t;

    // Write-channel and read-channel state.
    logic        awHeld_reg,  awHeld_next;
    logic [11:0] awAddr_reg,  awAddr_next;
    logic        wHeld_reg,   wHeld_next;
    logic [31:0] wData_reg,   wData_next;
    logic [3:0]  wStrb_reg,   wStrb_next;
    logic        bValid_reg,  bValid_next;
    logic [1:0]  bResp_reg,   bResp_next;
    logic        rValid_reg,  rValid_next;
    logic [31:0] rData_reg,   rData_next;
    logic [1:0]  rResp_reg,   rResp_next;
    // Register contents.
    logic        compat_reg,  compat_next;
    logic        xDis_reg,    xDis_next;
    logic        speed_reg,   speed_next;
    logic [15:0] seed_reg,    seed_next;
    logic        seedLoad_reg, seedLoad_next;
    // Retrain sequencing and speed-up tracking.
    plt_retrain_t rtState_reg, rtState_next;
    logic [31:0] rtCount_reg, rtCount_next;
    logic        force_reg,   force_next;
    logic        firstL0_reg, firstL0_next;
    logic        spdReq_reg,  spdReq_next;
    logic        strapDone_reg, strapDone_next;

    logic        doWrite;
    logic [31:0] mergedData;

    // Known decode shared by read and write paths.
    function automatic logic addrHit(input logic [11:0] a);
        addrHit = (a == plt_pkg::ADDR_LINK_CONFIG) ||
                  (a == plt_pkg::ADDR_LINK_RETRAIN) ||
                  (a == plt_pkg::ADDR_PRBS_SEED);
    endfunction : addrHit

    // Apply byte strobes to a 32-bit image.
    function automatic logic [31:0] applyStrb(input logic [31:0] old,
                                              input logic [31:0] nw,
                                              input logic [3:0]  st);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                res[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        applyStrb = res;
    endfunction : applyStrb

    // Readback image of one register; reserved bits stay zero.
    function automatic logic [31:0] readImage(input logic [11:0] a,
                                              input logic        c,
                                              input logic        x,
                                              input logic        s,
                                              input logic [15:0] sd);
        logic [31:0] v;
        v = '0;
        if (a == plt_pkg::ADDR_LINK_CONFIG) begin
            v[plt_pkg::BIT_COMPAT]    = c;
            v[plt_pkg::BIT_XLINK_DIS] = x;
            v[plt_pkg::BIT_SPEED_CTL] = s;
        end else if (a == plt_pkg::ADDR_PRBS_SEED) begin
            v[plt_pkg::SEED_WIDTH-1:0] = sd;
        end
        // Retrain register reads zero, trigger bit included.
        readImage = v;
    endfunction : readImage

    // ==========================================================
    // AXI4-Lite channels
    // ==========================================================
    // A write is committed once address and data are both held and the
    // response slot is free; this also orders the response first.
    assign doWrite    = awHeld_reg && wHeld_reg && !bValid_reg;
    assign mergedData = applyStrb(readImage(awAddr_reg, compat_reg,
                                            xDis_reg, speed_reg, seed_reg),
                                  wData_reg, wStrb_reg);

    always_comb begin
        awHeld_next = awHeld_reg;
        awAddr_next = awAddr_reg;
        wHeld_next  = wHeld_reg;
        wData_next  = wData_reg;
        wStrb_next  = wStrb_reg;
        bValid_next = bValid_reg;
        bResp_next  = bResp_reg;
        rValid_next = rValid_reg;
        rData_next  = rData_reg;
        rResp_next  = rResp_reg;
        if (s_axi_awvalid && !awHeld_reg) begin
            awHeld_next = 1'b1;
            awAddr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && !wHeld_reg) begin
            wHeld_next = 1'b1;
            wData_next = s_axi_wdata;
            wStrb_next = s_axi_wstrb;
        end
        if (bValid_reg && s_axi_bready) begin
            bValid_next = 1'b0;
        end
        if (doWrite) begin
            awHeld_next = 1'b0;
            wHeld_next  = 1'b0;
            bValid_next = 1'b1;
            bResp_next  = addrHit(awAddr_reg) ? plt_pkg::RESP_OKAY
                                              : plt_pkg::RESP_SLVERR;
        end
        if (rValid_reg && s_axi_rready) begin
            rValid_next = 1'b0;
        end
        if (s_axi_arvalid && !rValid_reg) begin
            rValid_next = 1'b1;
            rData_next  = readImage(s_axi_araddr, compat_reg, xDis_reg,
                                    speed_reg, seed_reg);
            rResp_next  = addrHit(s_axi_araddr) ? plt_pkg::RESP_OKAY
                                                : plt_pkg::RESP_SLVERR;
        end
    end

    // ==========================================================
    // Register fields and retrain sequencing
    // ==========================================================
    always_comb begin
        compat_next    = compat_reg;
        xDis_next      = xDis_reg;
        speed_next     = speed_reg;
        seed_next      = seed_reg;
        seedLoad_next  = 1'b0;
        rtState_next   = rtState_reg;
        rtCount_next   = rtCount_reg;
        force_next     = 1'b0;
        firstL0_next   = firstL0_reg;
        spdReq_next    = 1'b0;
        strapDone_next = 1'b1;
        // Speed bit reset follows the port mode, caught after release.
        if (!strapDone_reg) begin
            speed_next = !downstreamPort;
        end
        if (doWrite && awAddr_reg == plt_pkg::ADDR_LINK_CONFIG) begin
            compat_next = mergedData[plt_pkg::BIT_COMPAT];
            xDis_next   = mergedData[plt_pkg::BIT_XLINK_DIS];
            speed_next  = mergedData[plt_pkg::BIT_SPEED_CTL];
        end
        if (doWrite && awAddr_reg == plt_pkg::ADDR_PRBS_SEED) begin
            seed_next = mergedData[plt_pkg::SEED_WIDTH-1:0];
            // Only an actual change restarts the sequence.
            seedLoad_next = (seed_next != seed_reg);
        end
        case (rtState_reg)
            RT_IDLE: begin
                if (doWrite && awAddr_reg == plt_pkg::ADDR_LINK_RETRAIN &&
                    wStrb_reg[3] && wData_reg[plt_pkg::BIT_RETRAIN]) begin
                    rtState_next = RT_WAIT_RESP;
                end
            end
            RT_WAIT_RESP: begin
                // Hold off until the response has been accepted.
                if (!bValid_reg) begin
                    if (downstreamPort) begin
                        force_next   = 1'b1;
                        rtState_next = RT_IDLE;
                    end else begin
                        rtCount_next = 32'(UP_DELAY - 1);
                        rtState_next = RT_DELAY;
                    end
                end
            end
            RT_DELAY: begin
                if (rtCount_reg == '0) begin
                    force_next   = 1'b1;
                    rtState_next = RT_IDLE;
                end else begin
                    rtCount_next = rtCount_reg - 32'h0000_0001;
                end
            end
            default: begin
                rtState_next = RT_IDLE;
            end
        endcase
        // One automatic speed-up after the first L0 since Detect.
        if (force_reg) begin
            firstL0_next = 1'b0;
        end else if (ltssmInL0 && !firstL0_reg) begin
            firstL0_next = 1'b1;
            spdReq_next  = !speed_reg && gen2Permitted && !compat_reg;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            awHeld_reg    <= 1'b0;
            awAddr_reg    <= '0;
            wHeld_reg     <= 1'b0;
            wData_reg     <= '0;
            wStrb_reg     <= '0;
            bValid_reg    <= 1'b0;
            bResp_reg     <= plt_pkg::RESP_OKAY;
            rValid_reg    <= 1'b0;
            rData_reg     <= '0;
            rResp_reg     <= plt_pkg::RESP_OKAY;
            compat_reg    <= 1'b0;
            xDis_reg      <= 1'b0;
            speed_reg     <= 1'b1;
            seed_reg      <= plt_pkg::SEED_RESET;
            seedLoad_reg  <= 1'b0;
            rtState_reg   <= RT_IDLE;
            rtCount_reg   <= '0;
            force_reg     <= 1'b0;
            firstL0_reg   <= 1'b0;
            spdReq_reg    <= 1'b0;
            strapDone_reg <= 1'b0;
        end else begin
            awHeld_reg    <= awHeld_next;
            awAddr_reg    <= awAddr_next;
            wHeld_reg     <= wHeld_next;
            wData_reg     <= wData_next;
            wStrb_reg     <= wStrb_next;
            bValid_reg    <= bValid_next;
            bResp_reg     <= bResp_next;
            rValid_reg    <= rValid_next;
            rData_reg     <= rData_next;
            rResp_reg     <= rResp_next;
            compat_reg    <= compat_next;
            xDis_reg      <= xDis_next;
            speed_reg     <= speed_next;
            seed_reg      <= seed_next;
            seedLoad_reg  <= seedLoad_next;
            rtState_reg   <= rtState_next;
            rtCount_reg   <= rtCount_next;
            force_reg     <= force_next;
            firstL0_reg   <= firstL0_next;
            spdReq_reg    <= spdReq_next;
            strapDone_reg <= strapDone_next;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign s_axi_awready = !awHeld_reg;
    assign s_axi_wready  = !wHeld_reg;
    assign s_axi_bvalid  = bValid_reg;
    assign s_axi_bresp   = bResp_reg;
    assign s_axi_arready = !rValid_reg;
    assign s_axi_rvalid  = rValid_reg;
    assign s_axi_rdata   = rData_reg;
    assign s_axi_rresp   = rResp_reg;
    assign trainOpts.compatMode   = compat_reg;
    assign trainOpts.crossDisable = xDis_reg;
    assign trainOpts.autoSpeedUp  = !speed_reg;
    assign forceDetect    = force_reg;
    assign speedChangeReq = spdReq_reg;

    plt_prbs_gen u_prbs (
        .clock     (clock),
        .rst_n     (rst_n),
        .loadSeed  (seedLoad_reg),
        .seed      (seed_reg),
        .prbsValue (prbsValue)
    );
endmodule : plt_link_ctrl

// ### hdl/plt_pkg.sv
// Package with register map, field layout and types of the PHY link control.
package plt_pkg;
    // ==========================================================
    // Register map
    // ==========================================================
    localparam logic [11:0] ADDR_LINK_CONFIG  = 12'h530;
    localparam logic [11:0] ADDR_LINK_RETRAIN = 12'h540;
    localparam logic [11:0] ADDR_PRBS_SEED    = 12'h55C;

    // ==========================================================
    // Field positions and reset values
    // ==========================================================
    localparam int          BIT_COMPAT      = 8;
    localparam int          BIT_XLINK_DIS   = 11;
    localparam int          BIT_SPEED_CTL   = 14;
    localparam int          BIT_RETRAIN     = 31;
    localparam int          SEED_WIDTH      = 16;
    localparam logic [15:0] SEED_RESET      = 16'hFFFF;
    localparam logic [15:0] PRBS_TAPS       = 16'hB400;
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int CLOCK_MHZ        = 125;
    localparam int UP_DELAY_US      = 1000;
    localparam int UP_DELAY_CYCLES  = UP_DELAY_US * CLOCK_MHZ;

    // Link-training options handed to the LTSSM.
    typedef struct packed {
        logic compatMode;
        logic crossDisable;
        logic autoSpeedUp;
    } plt_train_opts_t;
endpackage : plt_pkg

// ### hdl/plt_prbs_gen.sv
// Seeded PRBS counter used during crosslink training.
module plt_prbs_gen (
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        loadSeed,
    input  wire logic [15:0] seed,
    output logic      [15:0] prbsValue
);
    logic [15:0] lfsr_reg;
    logic [15:0] lfsr_next;

    // ==========================================================
    // Galois LFSR step; a seed change reloads and restarts it.
    // ==========================================================
    always_comb begin
        if (loadSeed) begin
            lfsr_next = seed;
        end else if (lfsr_reg[0]) begin
            lfsr_next = (lfsr_reg >> 1) ^ plt_pkg::PRBS_TAPS;
        end else begin
            lfsr_next = lfsr_reg >> 1;
        end
    end

    // Register stage only.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            lfsr_reg <= plt_pkg::SEED_RESET;
        end else begin
            lfsr_reg <= lfsr_next;
        end
    end

    assign prbsValue = lfsr_reg;
endmodule : plt_prbs_gen

// ### dv/plt_link_monitor.sv
// Concurrent checks on the ports of the PHY link control block.
module plt_link_monitor #(
    parameter int UP_DELAY = 20
) (
    input wire logic                     clock,
    input wire logic                     rst_n,
    input wire logic                     downstreamPort,
    input wire logic                     gen2Permitted,
    input wire logic                     s_axi_bvalid,
    input wire logic                     s_axi_bready,
    input wire logic                     s_axi_rvalid,
    input wire logic [31:0]              s_axi_rdata,
    input wire plt_pkg::plt_train_opts_t trainOpts,
    input wire logic                     forceDetect,
    input wire logic                     speedChangeReq,
    input wire logic [15:0]              prbsValue
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [31:0] sinceResp_reg;
    logic [31:0] sinceRespNext;

    // ==========================================================
    // Helper counter
    // ==========================================================
    // Cycles since the last write response; saturates so it never wraps.
    always_comb begin
        sinceRespNext = sinceResp_reg;
        if (s_axi_bvalid && s_axi_bready) begin
            sinceRespNext = 32'h0;
        end else if (sinceResp_reg != 32'hFFFFFFFF) begin
            sinceRespNext = sinceResp_reg + 32'h1;
        end
    end

    // Register the counter.
    always_ff @(posedge clock) begin
        if (!rst_n) sinceResp_reg <= 32'h0;
        else sinceResp_reg <= sinceRespNext;
    end

    // ==========================================================
    // Properties
    // ==========================================================
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    property p_retrain_zero; s_axi_rvalid |-> !s_axi_rdata[31]; endproperty
    a_retrain_zero: assert property (p_retrain_zero)
        else $error("read data bit 31 set");
    property p_rsv_zero; s_axi_rvalid |-> s_axi_rdata[30:16] == 15'h0;
    endproperty
    a_rsv_zero: assert property (p_rsv_zero)
        else $error("reserved read bits set");
    property p_resp_first; forceDetect |-> !s_axi_bvalid; endproperty
    a_resp_first: assert property (p_resp_first)
        else $error("detect forced while response pending");
    property p_pulse; forceDetect |=> !forceDetect; endproperty
    a_pulse: assert property (p_pulse)
        else $error("detect pulse longer than one cycle");
    // The full upstream delay must pass after the response is accepted.
    property p_up_wait;
        forceDetect && !downstreamPort |-> sinceResp_reg >= UP_DELAY;
    endproperty
    a_up_wait: assert property (p_up_wait)
        else $error("upstream retrain too early");
    property p_down_soon;
        forceDetect && downstreamPort |-> sinceResp_reg <= 32'h3;
    endproperty
    a_down_soon: assert property (p_down_soon)
        else $error("downstream retrain late");
    property p_speed;
        speedChangeReq |-> trainOpts.autoSpeedUp && gen2Permitted
            && !trainOpts.compatMode;
    endproperty
    a_speed: assert property (p_speed)
        else $error("speed change without permission");
    property p_seed_reset; $rose(rst_n) |-> prbsValue == 16'hFFFF; endproperty
    a_seed_reset: assert property (p_seed_reset)
        else $error("sequence not at reset seed");
endmodule : plt_link_monitor

// ### dv/plt_ltssm_model.sv
// Behavioural link partner: re-enters L0 a few cycles after Detect.
module plt_ltssm_model #(
    parameter int TRAIN = 6
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic forceDetect,
    output logic     ltssmInL0
);
    timeunit 1ns;
    timeprecision 1ps;

    int trainCnt_reg;
    int trainCntNext;

    // A forced Detect restarts training, so L0 drops at once.
    always_comb begin
        trainCntNext = trainCnt_reg;
        if (forceDetect) trainCntNext = 0;
        else if (trainCnt_reg < TRAIN) trainCntNext = trainCnt_reg + 1;
    end

    // Register the training count.
    always_ff @(posedge clock) begin
        if (!rst_n) trainCnt_reg <= 0;
        else trainCnt_reg <= trainCntNext;
    end

    assign ltssmInL0 = (trainCnt_reg == TRAIN);
endmodule : plt_ltssm_model

// ### dv/testbench.sv
// Self-checking bench of the PHY link control registers.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int UP_DELAY = 20;
    localparam int LIMIT    = 20000;
    localparam logic [31:0] SP_CFG [4] = '{32'h0, 32'h4000, 32'h0, 32'h100};
    localparam logic [3:0]  SP_G2  = 4'hB;
    localparam logic [3:0]  SP_INC = 4'h1;
    logic clock, rst_n, downstreamPort, ltssmInL0, gen2Permitted;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready, forceDetect, speedChangeReq;
    logic [15:0] prbsValue;
    plt_pkg::plt_train_opts_t trainOpts;
    int n_fail, cmp_count, cyc, lastB, fdCyc, speedCnt;

    plt_link_ctrl #(.UP_DELAY(UP_DELAY)) plt_link_ctrl_i (
        .clock(clock), .rst_n(rst_n), .downstreamPort(downstreamPort),
        .ltssmInL0(ltssmInL0), .gen2Permitted(gen2Permitted),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .trainOpts(trainOpts),
        .forceDetect(forceDetect), .speedChangeReq(speedChangeReq),
        .prbsValue(prbsValue));
    plt_ltssm_model plt_ltssm_model_i (.clock(clock), .rst_n(rst_n),
        .forceDetect(forceDetect), .ltssmInL0(ltssmInL0));

    // ==========================================================
    // Clock, cycle count and watchdog
    // ==========================================================
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    // Tracks detect pulses and speed requests; cuts a hang short.
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (forceDetect === 1'b1) fdCyc <= cyc;
        if (speedChangeReq === 1'b1) speedCnt <= speedCnt + 1;
        if (cyc == LIMIT) begin
            n_fail++;
            wrap_up();
        end
    end

    // ==========================================================
    // Shared tasks
    // ==========================================================
    task automatic chk(input logic [31:0] got, exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    // Address and data go out together; each is dropped once taken.
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        @(posedge clock);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        lastB = cyc;
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        @(posedge clock);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : wrap_up

    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic t_reset_vals();
        logic [31:0] d;
        logic [1:0]  r;
        rd(plt_pkg::ADDR_LINK_CONFIG, d, r);
        chk(d, 32'h0, "config reset downstream");
        rd(plt_pkg::ADDR_LINK_RETRAIN, d, r);
        chk(d, 32'h0, "retrain reset");
        rd(plt_pkg::ADDR_PRBS_SEED, d, r);
        chk(d, 32'h0000FFFF, "seed reset");
        chk({29'h0, trainOpts}, 32'h1, "options at reset");
        $display("t_reset_vals done");
    endtask : t_reset_vals

    task automatic t_config();
        logic [31:0] d;
        logic [1:0]  r;
        wr(plt_pkg::ADDR_LINK_CONFIG, 32'hFFFFFFFF, r);
        chk({30'h0, r}, {30'h0, plt_pkg::RESP_OKAY}, "config resp");
        rd(plt_pkg::ADDR_LINK_CONFIG, d, r);
        chk(d, 32'h00004900, "config all ones");
        chk({29'h0, trainOpts}, 32'h6, "compat and no crosslink");
        wr(plt_pkg::ADDR_LINK_CONFIG, 32'h0, r);
        chk({29'h0, trainOpts}, 32'h1, "options cleared");
        $display("t_config done");
    endtask : t_config

    // Each case retrains and counts the speed requests that follow.
    task automatic t_speed();
        logic [1:0] r;
        int n;
        for (int i = 0; i < 4; i++) begin
            gen2Permitted <= SP_G2[i];
            wr(plt_pkg::ADDR_LINK_CONFIG, SP_CFG[i], r);
            n = speedCnt;
            wr(plt_pkg::ADDR_LINK_RETRAIN, 32'h80000000, r);
            repeat (40) @(posedge clock);
            chk(32'(speedCnt - n), {31'h0, SP_INC[i]},
                "speed");
            chk({31'h0, fdCyc >= lastB && fdCyc <= lastB + 4}, 32'h1,
                "detect soon");
        end
        $display("t_speed done");
    endtask : t_speed

    task automatic t_upstream();
        logic [31:0] d;
        logic [1:0]  r;
        int f0;
        @(posedge clock);
        downstreamPort <= 1'b0;
        rst_n          <= 1'b0;
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        repeat (2) @(posedge clock);
        rd(plt_pkg::ADDR_LINK_CONFIG, d, r);
        chk(d, 32'h00004000, "config reset upstream");
        f0 = fdCyc;
        wr(plt_pkg::ADDR_LINK_RETRAIN, 32'h80000000, r);
        repeat (UP_DELAY - 4) @(posedge clock);
        chk(32'(fdCyc), 32'(f0), "no early detect");
        repeat (10) @(posedge clock);
        chk({31'h0, fdCyc >= lastB + UP_DELAY - 2
            && fdCyc <= lastB + UP_DELAY + 4}, 32'h1, "late detect");
        rd(plt_pkg::ADDR_LINK_RETRAIN, d, r);
        chk(d, 32'h0, "retrain reads zero");
        $display("t_upstream done");
    endtask : t_upstream

    task automatic t_seed_unmapped();
        logic [31:0] d;
        logic [1:0]  r;
        logic        hit;
        hit = 1'b0;
        wr(plt_pkg::ADDR_PRBS_SEED, 32'hABCD1234, r);
        repeat (4) @(posedge clock) if (prbsValue === 16'h1234) hit = 1'b1;
        chk({31'h0, hit}, 32'h1, "seed reload");
        rd(plt_pkg::ADDR_PRBS_SEED, d, r);
        chk(d, 32'h00001234, "seed readback");
        rd(12'h534, d, r);
        chk(d, 32'h0, "unmapped read data");
        chk({30'h0, r}, {30'h0, plt_pkg::RESP_SLVERR}, "unmapped rd");
        wr(12'h534, 32'hFFFFFFFF, r);
        chk({30'h0, r}, {30'h0, plt_pkg::RESP_SLVERR},
            "unmapped write");
        $display("t_seed_unmapped done");
    endtask : t_seed_unmapped

    // Main sequence: reset, then every scenario in turn.
    initial begin
        {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
        {s_axi_arvalid, s_axi_rready} = 2'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        {n_fail, cmp_count, cyc, lastB, fdCyc, speedCnt} = '0;
        downstreamPort = 1'b1;
        gen2Permitted  = 1'b1;
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        repeat (3) @(posedge clock);
        t_reset_vals();
        t_config();
        t_speed();
        t_seed_unmapped();
        t_upstream();
        wrap_up();
    end
endmodule : testbench

bind plt_link_ctrl plt_link_monitor #(.UP_DELAY(UP_DELAY)) plt_link_monitor_i (
    .clock(clock), .rst_n(rst_n), .downstreamPort(downstreamPort),
    .gen2Permitted(gen2Permitted), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rdata(s_axi_rdata), .trainOpts(trainOpts),
    .forceDetect(forceDetect), .speedChangeReq(speedChangeReq),
    .prbsValue(prbsValue));
